// *** thermal_sensor_regs.svh ***
// Command codes, register resets and timing constants of the thermal sensor
// Contract
// - Recognise exactly five management bus packet kinds
// - Send byte carries only the one-shot command
// - Receive byte returns last read-byte command's register
// - Sensor drives acks and returned data only
// - Write byte: address, command, data, each acked
// - Read byte: command, repeated start, returned byte
// - Send byte: address, command, acks, stop
// - Receive byte: address read, returned byte, nack
// - Alert response read at fixed address
// - Alert reply carries own address upper bits
// - Codes 01h-03h read reading, status, configuration
// - Rate reads 04h, resets 02h; configuration zero
// - Limits read 07h/08h, reset 7fh/c9h
// - Writes 09h, 0ah, 0dh, 0eh update registers
// - Code 0fh by send byte starts conversion
// - One-shot during busy conversion is dropped
// - Standby one-shot converts once then stays standby
// - Selected command resets to reserved 00h
// - Reading saturates to signed eight bits
// - Limit crossing asserts active-low bus alert
// - Alarm when reading equals or passes limit
// - Status read clears alarms unless still true
// - Configuration bit six selects standby
// - Rate codes 00h-07h double from 0.0625 Hz
`ifndef THERMAL_SENSOR_REGS_SVH
`define THERMAL_SENSOR_REGS_SVH

`define ADDR_W            7
`define BYTE_W            8
`define ADC_RAW_W         10
`define BIT_LAST          4'h8
`define ARA_ADDR          7'h0c
`define STRAP_CAP_CNT     2'h2

`define CMD_RESERVED      8'h00
`define CMD_RD_TEMP       8'h01
`define CMD_RD_STATUS     8'h02
`define CMD_RD_CONFIG     8'h03
`define CMD_RD_RATE       8'h04
`define CMD_RD_HIGH       8'h07
`define CMD_RD_LOW        8'h08
`define CMD_WR_CONFIG     8'h09
`define CMD_WR_RATE       8'h0a
`define CMD_WR_HIGH       8'h0d
`define CMD_WR_LOW        8'h0e
`define CMD_ONE_SHOT      8'h0f

`define CONFIG_RESET      8'h00
`define RATE_RESET        8'h02
`define HIGH_LIMIT_RESET  8'h7f
`define LOW_LIMIT_RESET   8'hc9
`define CONFIG_WRITE_MASK 8'h40
`define CONFIG_STOP_BIT   6
`define READ_INVALID      8'h00
`define STATUS_PAD        2'h0

`define TEMP_MAX          8'h7f
`define TEMP_MIN          8'h80
`define TEMP_MAX_RAW      10'sh07f
`define TEMP_MIN_RAW      10'sh380

`define RATE_MAX_CODE     8'h07
`define RATE_RESERVED_SEL 3'h0
`define PERIOD_MASK_ALL   7'h7f
`define CORE_CLK_PERIOD_NS 100
`define CONV_TICK_US      125000
`define CONV_TICK_CYCLES  ((`CONV_TICK_US * 1000) / `CORE_CLK_PERIOD_NS)

`endif

// *** thermal_sensor_pkg.sv ***
// Types shared by the thermal sensor slave and its conversion scheduler
`default_nettype none
`include "thermal_sensor_regs.svh"
package thermal_sensor_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_CMD  = 3'b010,
        ST_DATA = 3'b011,
        ST_ACK  = 3'b100,
        ST_TX   = 3'b101,
        ST_MACK = 3'b110,
        ST_WAIT = 3'b111
    } smb_state_t;

    typedef struct packed {
        logic                          done;
        logic                          open_fault;
        logic signed [`ADC_RAW_W-1:0]  raw;
    } adc_result_t;

endpackage
`default_nettype wire

// *** conv_scheduler.sv ***
// Conversion scheduler: timed auto conversions, one-shot, busy tracking
`default_nettype none
`include "thermal_sensor_regs.svh"
module conv_scheduler #(
    parameter int tick_cycles = `CONV_TICK_CYCLES
) (
    input  wire logic              core_clk,
    input  wire logic              nrst,
    input  wire logic              auto_mode,
    input  wire logic [`BYTE_W-1:0] rate_code,
    input  wire logic              one_shot,
    input  wire logic              conv_done,
    output logic                   conv_start,
    output logic                   busy
);
    import thermal_sensor_pkg::*;

    logic [31:0] tick_cnt;
    logic [6:0]  period_cnt;
    logic [2:0]  rate_sel;
    logic [6:0]  period_mask;
    logic        tick;
    logic        due;
    logic        start_ok;

    // ****************************************
    // Rate decode
    // ****************************************
    assign rate_sel = (rate_code > `RATE_MAX_CODE) ? `RATE_RESERVED_SEL
                                                   : rate_code[2:0];
    assign period_mask = `PERIOD_MASK_ALL >> rate_sel;
    assign tick = (tick_cnt == 32'(tick_cycles - 1));
    assign due = tick && ((period_cnt & period_mask) == period_mask);
    assign start_ok = !busy && (one_shot || (auto_mode && due));

    // ****************************************
    // Timers
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!nrst || !auto_mode) begin
            tick_cnt <= 32'h0;
            period_cnt <= 7'h0;
        end else begin
            tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
            if (tick) begin
                period_cnt <= period_cnt + 7'h1;
            end
        end
    end

    // ****************************************
    // Start and busy
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            conv_start <= 1'b0;
            busy <= 1'b0;
        end else begin
            conv_start <= start_ok;
            if (start_ok) begin
                busy <= 1'b1;
            end else if (conv_done) begin
                busy <= 1'b0;
            end
        end
    end

endmodule // conv_scheduler
`default_nettype wire

// *** smbus_thermal_sensor_regs.sv ***
// SMBus thermal sensor slave: packet decode, registers, limits and alert
`default_nettype none
`include "thermal_sensor_regs.svh"
module smbus_thermal_sensor_regs #(
    parameter int conv_tick_cycles = `CONV_TICK_CYCLES
) (
    input  wire logic                            core_clk,
    input  wire logic                            nrst,
    input  wire logic                            scl_in,
    input  wire logic                            sda_in,
    output logic                                 sda_out,
    output logic                                 sda_oe,
    input  wire logic [`ADDR_W-1:0]              addr_strap,
    input  wire thermal_sensor_pkg::adc_result_t adc,
    output logic                                 conv_start,
    output logic                                 bus_alert_n
);
    import thermal_sensor_pkg::*;

    logic               scl_meta;
    logic               scl_sync;
    logic               scl_q;
    logic               sda_meta;
    logic               sda_sync;
    logic               sda_q;
    logic [`ADDR_W-1:0] strap_meta;
    logic [`ADDR_W-1:0] strap_sync;
    logic [`ADDR_W-1:0] own_addr;
    logic [1:0]         cap_cnt;
    smb_state_t         state;
    smb_state_t         ack_ret;
    logic [3:0]         bit_cnt;
    logic [`BYTE_W-1:0] shift;
    logic [`BYTE_W-1:0] tx_shift;
    logic [`BYTE_W-1:0] cur_cmd;
    logic [`BYTE_W-1:0] cmd_sel;
    logic               cmd_valid;
    logic               is_ara;
    logic [`BYTE_W-1:0] cfg;
    logic [`BYTE_W-1:0] rate;
    logic [`BYTE_W-1:0] hi_lim;
    logic [`BYTE_W-1:0] lo_lim;
    logic [`BYTE_W-1:0] reading;
    logic               high_flag;
    logic               low_flag;
    logic               open_flag;
    logic               busy;

    // ****************************************
    // Decode wires
    // ****************************************
    wire scl_rise  = scl_sync && !scl_q;
    wire scl_fall  = !scl_sync && scl_q;
    wire start_det = scl_sync && scl_q && sda_q && !sda_sync;
    wire stop_det  = scl_sync && scl_q && !sda_q && sda_sync;
    wire rx_state  = (state == ST_ADDR) || (state == ST_CMD) ||
                     (state == ST_DATA);
    wire byte_done = rx_state && scl_fall && (bit_cnt == `BIT_LAST);
    wire addr_hit  = (shift[7:1] == own_addr);
    wire ara_hit   = (shift[7:1] == `ARA_ADDR) && shift[0] &&
                     !bus_alert_n;
    wire send_end  = (state == ST_DATA) && (bit_cnt <= 4'h1) && cmd_valid;
    wire one_shot  = stop_det && send_end &&
                     (cur_cmd == `CMD_ONE_SHOT);
    wire wr_fire   = byte_done && (state == ST_DATA);
    wire tx_load   = (state == ST_ACK) && (ack_ret == ST_TX) && scl_fall;
    wire status_clear = (state == ST_MACK) && scl_rise && !is_ara &&
                        (cmd_sel == `CMD_RD_STATUS);
    wire is_wr_cmd = (cur_cmd == `CMD_WR_CONFIG) ||
                     (cur_cmd == `CMD_WR_RATE) ||
                     (cur_cmd == `CMD_WR_HIGH) ||
                     (cur_cmd == `CMD_WR_LOW);
    wire [`BYTE_W-1:0] status_byte = {busy, `STATUS_PAD, high_flag,
                                      low_flag, open_flag, `STATUS_PAD};

    // Register selected by a read command
    function automatic logic [`BYTE_W-1:0] read_value(
        input logic [`BYTE_W-1:0] cmd
    );
        case (cmd)
            `CMD_RD_TEMP:   read_value = reading;
            `CMD_RD_STATUS: read_value = status_byte;
            `CMD_RD_CONFIG: read_value = cfg;
            `CMD_RD_RATE:   read_value = rate;
            `CMD_RD_HIGH:   read_value = hi_lim;
            `CMD_RD_LOW:    read_value = lo_lim;
            default:        read_value = `READ_INVALID;
        endcase
    endfunction

    wire [`BYTE_W-1:0] tx_byte = is_ara ? {own_addr, 1'b1}
                                        : read_value(cmd_sel);

    // Saturation and limit compare
    wire signed [`ADC_RAW_W-1:0] raw = adc.raw;
    wire [`BYTE_W-1:0] sat_val = (raw > `TEMP_MAX_RAW) ? `TEMP_MAX :
                                 (raw < `TEMP_MIN_RAW) ? `TEMP_MIN :
                                 raw[`BYTE_W-1:0];
    wire hi_hit  = adc.done && ($signed(sat_val) >= $signed(hi_lim));
    wire lo_hit  = adc.done && ($signed(sat_val) <= $signed(lo_lim));
    wire hi_cond = $signed(reading) >= $signed(hi_lim);
    wire lo_cond = $signed(reading) <= $signed(lo_lim);
    wire next_high = hi_hit || (high_flag &&
                     !(status_clear && !hi_cond));
    wire next_low  = lo_hit || (low_flag &&
                     !(status_clear && !lo_cond));

    // ****************************************
    // Pin synchronisers and address strap
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_q <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_meta <= scl_in;
            scl_sync <= scl_meta;
            scl_q <= scl_sync;
            sda_meta <= sda_in;
            sda_sync <= sda_meta;
            sda_q <= sda_sync;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            strap_meta <= 7'h00;
            strap_sync <= 7'h00;
            own_addr <= 7'h00;
            cap_cnt <= 2'h0;
        end else begin
            strap_meta <= addr_strap;
            strap_sync <= strap_meta;
            if (cap_cnt != 2'h3) begin
                cap_cnt <= cap_cnt + 2'h1;
            end
            if (cap_cnt == `STRAP_CAP_CNT) begin
                own_addr <= strap_sync;
            end
        end
    end

    // ****************************************
    // Packet state machine
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state <= ST_IDLE;
            ack_ret <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            tx_shift <= 8'h00;
            sda_oe <= 1'b0;
            is_ara <= 1'b0;
            cmd_valid <= 1'b0;
            cur_cmd <= `CMD_RESERVED;
            cmd_sel <= `CMD_RESERVED;
        end else if (stop_det) begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
            cmd_valid <= 1'b0;
        end else if (start_det) begin
            if (send_end) begin
                cmd_sel <= cur_cmd;
            end
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            sda_oe <= 1'b0;
            cmd_valid <= 1'b0;
        end else begin
            case (state)
                ST_ADDR, ST_CMD, ST_DATA: begin
                    if (scl_rise) begin
                        shift <= {shift[6:0], sda_sync};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt <= 4'h0;
                        if (state == ST_ADDR) begin
                            if (addr_hit || ara_hit) begin
                                sda_oe <= 1'b1;
                                state <= ST_ACK;
                                is_ara <= ara_hit && !addr_hit;
                                ack_ret <= shift[0] ? ST_TX
                                                    : ST_CMD;
                            end else begin
                                state <= ST_WAIT;
                            end
                        end else if (state == ST_CMD) begin
                            cur_cmd <= shift;
                            cmd_valid <= 1'b1;
                            sda_oe <= 1'b1;
                            state <= ST_ACK;
                            ack_ret <= ST_DATA;
                        end else begin
                            cmd_valid <= 1'b0;
                            sda_oe <= 1'b1;
                            state <= ST_ACK;
                            ack_ret <= ST_WAIT;
                        end
                    end
                end
                ST_ACK: begin
                    if (tx_load) begin
                        tx_shift <= tx_byte;
                        sda_oe <= !tx_byte[7];
                        bit_cnt <= 4'h1;
                        state <= ST_TX;
                    end else if (scl_fall) begin
                        sda_oe <= 1'b0;
                        state <= ack_ret;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt == `BIT_LAST) begin
                            sda_oe <= 1'b0;
                            state <= ST_MACK;
                        end else begin
                            tx_shift <= {tx_shift[6:0], 1'b0};
                            sda_oe <= !tx_shift[6];
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        state <= ST_WAIT;
                    end
                end
                ST_IDLE, ST_WAIT: begin
                    sda_oe <= 1'b0;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Registers, alarms and alert
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cfg <= `CONFIG_RESET;
            rate <= `RATE_RESET;
            hi_lim <= `HIGH_LIMIT_RESET;
            lo_lim <= `LOW_LIMIT_RESET;
        end else if (wr_fire) begin
            case (cur_cmd)
                `CMD_WR_CONFIG: cfg <= shift & `CONFIG_WRITE_MASK;
                `CMD_WR_RATE:   rate <= shift;
                `CMD_WR_HIGH:   hi_lim <= shift;
                `CMD_WR_LOW:    lo_lim <= shift;
                default:        cfg <= cfg;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            reading <= 8'h00;
            open_flag <= 1'b0;
            high_flag <= 1'b0;
            low_flag <= 1'b0;
            bus_alert_n <= 1'b1;
            sda_out <= 1'b0;
        end else begin
            if (adc.done) begin
                reading <= sat_val;
                open_flag <= adc.open_fault;
            end
            high_flag <= next_high;
            low_flag <= next_low;
            bus_alert_n <= !(next_high || next_low);
            sda_out <= 1'b0;
        end
    end

    // ****************************************
    // Conversion scheduling
    // ****************************************
    conv_scheduler #(
        .tick_cycles (conv_tick_cycles)
    ) u_sched (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .auto_mode  (!cfg[`CONFIG_STOP_BIT]),
        .rate_code  (rate),
        .one_shot   (one_shot),
        .conv_done  (adc.done),
        .conv_start (conv_start),
        .busy       (busy)
    );

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    addr_ack_a: assert property (
        byte_done && state == ST_ADDR && addr_hit |=> sda_oe && state == ST_ACK)
        else $error("own address not acknowledged");
    bad_addr_a: assert property (
        byte_done && state == ST_ADDR && !addr_hit && !ara_hit
        |=> !sda_oe && state == ST_WAIT)
        else $error("foreign address answered");
    read_sel_a: assert property (
        start_det && send_end |=> cmd_sel == $past(cur_cmd))
        else $error("read command not kept");
    temp_read_a: assert property (
        tx_load && !is_ara && cmd_sel == `CMD_RD_TEMP
        |=> tx_shift == $past(reading))
        else $error("wrong reading returned");
    ara_reply_a: assert property (
        tx_load && is_ara |=> tx_shift[7:1] == own_addr)
        else $error("alert reply lacks address");
    oneshot_go_a: assert property (
        one_shot && !busy |=> conv_start && busy)
        else $error("one-shot did not start");
    oneshot_drop_a: assert property (
        busy && !adc.done |=> !conv_start)
        else $error("start while busy");
    standby_hold_a: assert property (
        cfg[`CONFIG_STOP_BIT] && !one_shot |=> !conv_start)
        else $error("standby converted without one-shot");
    sat_high_a: assert property (
        adc.done && raw > `TEMP_MAX_RAW |=> reading == `TEMP_MAX)
        else $error("high saturation wrong");
    sat_low_a: assert property (
        adc.done && raw < `TEMP_MIN_RAW |=> reading == `TEMP_MIN)
        else $error("low saturation wrong");
    high_alarm_a: assert property (
        hi_hit |=> high_flag && !bus_alert_n)
        else $error("high alarm missed");
    flag_clear_a: assert property (
        status_clear && !adc.done && !hi_cond && !lo_cond
        |=> !high_flag && !low_flag ##1 bus_alert_n || low_flag || high_flag)
        else $error("alarm not cleared by status read");
    flag_hold_a: assert property (
        high_flag && !status_clear |=> high_flag)
        else $error("alarm dropped without status read");
    cfg_write_a: assert property (
        wr_fire && cur_cmd == `CMD_WR_CONFIG
        |=> cfg == ($past(shift) & `CONFIG_WRITE_MASK))
        else $error("configuration write lost");
    resv_write_a: assert property (
        wr_fire && !is_wr_cmd
        |=> $stable(cfg) && $stable(rate) && $stable(hi_lim) && $stable(lo_lim))
        else $error("reserved write changed a register");
    reset_regs_a: assert property (
        $rose(nrst) |-> cmd_sel == `CMD_RESERVED && cfg == `CONFIG_RESET &&
        rate == `RATE_RESET && hi_lim == `HIGH_LIMIT_RESET &&
        lo_lim == `LOW_LIMIT_RESET)
        else $error("reset values wrong");

    write_byte_c: cover property (wr_fire && cur_cmd == `CMD_WR_HIGH);
    status_read_c: cover property (status_clear);
    ara_reply_c: cover property (tx_load && is_ara);
    oneshot_c: cover property (one_shot && !busy);

endmodule // smbus_thermal_sensor_regs
`default_nettype wire

// *** smb_host_model.sv ***
// SMBus host controller model: starts, stops and byte transfers
`default_nettype none
module smb_host_model (
    input  wire logic core_clk,
    input  wire logic sda_oe,
    output logic      scl,
    output logic      sda
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sda_lo;
    // Pull-up on the data line: a released line reads high
    assign sda = ~(sda_lo | sda_oe);
    initial begin
        scl = 1'b1;
        sda_lo = 1'b0;
    end
    task automatic put(input logic c, input logic lo);
        scl <= c;
        sda_lo <= lo;
        repeat (12) @(posedge core_clk);
    endtask
    // Also a repeated start when the clock is low
    task automatic start();
        put(scl, 1'b0);
        put(1'b1, 1'b0);
        put(1'b1, 1'b1);
        put(1'b0, 1'b1);
    endtask
    task automatic stop();
        put(1'b0, 1'b1);
        put(1'b1, 1'b1);
        put(1'b1, 1'b0);
    endtask
    // Eight bits MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] b, input logic ab,
                        output logic [7:0] r, output logic ak);
        logic [8:0] o, s;
        o = {b, ab};
        for (int i = 8; i >= 0; i--) begin
            put(1'b0, ~o[i]);
            put(1'b1, ~o[i]);
            s[i] = sda;
            put(1'b0, ~o[i]);
        end
        r = s[8:1];
        ak = s[0];
    endtask
endmodule // smb_host_model
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the thermal sensor slave
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import thermal_sensor_pkg::*;
    localparam logic [6:0] own = 7'h2c;
    logic core_clk, nrst, scl, sda, sda_oe, sda_out, conv_start, bus_alert_n;
    adc_result_t adc;
    int fails, n_compared, n_conv;
    logic [7:0] d;
    smbus_thermal_sensor_regs #(.conv_tick_cycles(20))
        u_smbus_thermal_sensor_regs (.core_clk(core_clk), .nrst(nrst),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_strap(own), .adc(adc), .conv_start(conv_start),
        .bus_alert_n(bus_alert_n));
    smb_host_model u_smb_host_model (.core_clk(core_clk),
        .sda_oe(sda_oe), .scl(scl), .sda(sda));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        adc.done <= conv_start;
        if (conv_start)
            n_conv <= n_conv + 1;
    end
    task automatic check(input string nm, input logic [7:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tx(input logic [7:0] b);
        logic [7:0] r;
        logic a;
        u_smb_host_model.xfer(b, 1'b1, r, a);
        check("ack", {7'h0, a}, 8'h00);
    endtask
    task automatic rx(output logic [7:0] v);
        logic a;
        u_smb_host_model.xfer(8'hff, 1'b1, v, a);
        u_smb_host_model.stop();
    endtask
    task automatic wr(input logic [7:0] c, dat, input logic nodata);
        u_smb_host_model.start();
        tx({own, 1'b0});
        tx(c);
        if (!nodata)
            tx(dat);
        u_smb_host_model.stop();
    endtask
    task automatic rd(input logic [7:0] c, output logic [7:0] v);
        u_smb_host_model.start();
        tx({own, 1'b0});
        tx(c);
        u_smb_host_model.start();
        tx({own, 1'b1});
        rx(v);
    endtask
    task automatic rcv(input logic [6:0] a, output logic [7:0] v);
        u_smb_host_model.start();
        tx({a, 1'b1});
        rx(v);
    endtask
    task automatic t_reset();
        logic [7:0] rc[4] = '{8'h03, 8'h04, 8'h07, 8'h08};
        logic [7:0] re[4] = '{8'h00, 8'h02, 8'h7f, 8'hc9};
        logic a;
        check("alert idle", {7'h0, bus_alert_n}, 8'h01);
        check("drive level", {7'h0, sda_out}, 8'h00);
        u_smb_host_model.start();
        u_smb_host_model.xfer({7'h0c, 1'b1}, 1'b1, d, a);
        check("nack foreign", {7'h0, a}, 8'h01);
        u_smb_host_model.stop();
        rcv(own, d);
        check("rcv after reset", d, 8'h00);
        foreach (rc[i]) begin
            rd(rc[i], d);
            check("reset value", d, re[i]);
        end
    endtask
    task automatic t_regs();
        logic [7:0] rc[4] = '{8'h03, 8'h04, 8'h07, 8'h08};
        logic [7:0] re[4] = '{8'h40, 8'h05, 8'h50, 8'he0};
        wr(8'h0a, 8'h05, 1'b0);
        wr(8'h0d, 8'h50, 1'b0);
        wr(8'h0e, 8'he0, 1'b0);
        wr(8'h09, 8'hff, 1'b0);
        wr(8'h04, 8'h33, 1'b0);
        wr(8'h0b, 8'h11, 1'b0);
        foreach (rc[i]) begin
            rd(rc[i], d);
            check("register", d, re[i]);
        end
        rcv(own, d);
        check("rcv repeat", d, 8'he0);
    endtask
    task automatic shot(input logic [9:0] raw, input int n);
        int base;
        base = n_conv;
        adc.raw <= raw;
        wr(8'h0f, 8'h00, 1'b1);
        repeat (n) @(posedge core_clk);
        check("conversions", 8'(n_conv - base), 8'h01);
    endtask
    task automatic t_alarm();
        shot(10'h0c8, 2000);
        rd(8'h01, d);
        check("reading", d, 8'h7f);
        check("alert", {7'h0, bus_alert_n}, 8'h00);
        rcv(7'h0c, d);
        check("alert reply", {1'b0, d[7:1]}, {1'b0, own});
        rd(8'h02, d);
        check("status", d, 8'h10);
        rd(8'h02, d);
        check("status held", d, 8'h10);
        shot(10'h2d4, 40);
        rd(8'h02, d);
        check("status both", d, 8'h18);
        rd(8'h02, d);
        check("status cleared", d, 8'h08);
        rd(8'h01, d);
        check("reading low", d, 8'h80);
        shot(10'h000, 40);
        rd(8'h02, d);
        check("status last", d, 8'h08);
        rd(8'h02, d);
        check("status none", d, 8'h00);
        check("alert off", {7'h0, bus_alert_n}, 8'h01);
    endtask
    task automatic tally_and_finish();
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        nrst = 1'b0;
        adc = '0;
        fails = 0;
        n_compared = 0;
        n_conv = 0;
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (10) @(posedge core_clk);
        t_reset();
        t_regs();
        t_alarm();
        tally_and_finish();
    end
    initial begin
        repeat (90000) @(posedge core_clk);
        fails++;
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
